// File: hdl/itxo_pkg.sv
// Shared constants, types and helpers for the index transfer/exchange unit.
// Assumes a single core clock; all values here are used by the core and its timer.
package itxo_pkg;
    // APB register byte offsets
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_D = 8'h08;
    localparam logic [7:0] OFF_E = 8'h0C;
    localparam logic [7:0] OFF_IX1 = 8'h10;
    localparam logic [7:0] OFF_IX2 = 8'h14;
    localparam logic [7:0] OFF_IX3 = 8'h18;
    localparam logic [7:0] OFF_SP = 8'h1C;
    localparam logic [7:0] OFF_CCR = 8'h20;
    localparam logic [7:0] OFF_PULL = 8'h24;
    localparam logic [7:0] OFF_EK = 8'h28;
    localparam logic [7:0] OFF_TIMING = 8'h2C;

    // Opcodes handled by this unit
    localparam logic [15:0] OPC_WORD_ZERO_TEST_X = 16'h2706;
    localparam logic [15:0] OPC_WORD_ZERO_TEST_Y = 16'h2716;
    localparam logic [15:0] OPC_WORD_ZERO_TEST_Z = 16'h2726;
    localparam logic [15:0] OPC_WORD_ZERO_TEST_EXT = 16'h2736;
    localparam logic [15:0] OPC_TSX = 16'h274F;
    localparam logic [15:0] OPC_TSY = 16'h275F;
    localparam logic [15:0] OPC_TSZ = 16'h276F;
    localparam logic [15:0] OPC_TXS = 16'h374E;
    localparam logic [15:0] OPC_TYS = 16'h375E;
    localparam logic [15:0] OPC_TZS = 16'h376E;
    localparam logic [15:0] OPC_C12 = 16'h275C;
    localparam logic [15:0] OPC_C13 = 16'h276C;
    localparam logic [15:0] OPC_C21 = 16'h274D;
    localparam logic [15:0] OPC_C23 = 16'h276D;
    localparam logic [15:0] OPC_C31 = 16'h274E;
    localparam logic [15:0] OPC_C32 = 16'h275E;
    localparam logic [15:0] OPC_BK1 = 16'h37AC;
    localparam logic [15:0] OPC_BK2 = 16'h37AD;
    localparam logic [15:0] OPC_BK3 = 16'h37AE;
    localparam logic [15:0] OPC_WAIT = 16'h27F3;
    localparam logic [15:0] OPC_XAB = 16'h371A;
    localparam logic [15:0] OPC_XDE = 16'h277A;
    localparam logic [15:0] OPC_XD1 = 16'h37CC;
    localparam logic [15:0] OPC_XD2 = 16'h37DC;
    localparam logic [15:0] OPC_XD3 = 16'h37EC;
    localparam logic [15:0] OPC_XE1 = 16'h374C;
    localparam logic [15:0] OPC_XE2 = 16'h375C;
    localparam logic [15:0] OPC_XE3 = 16'h376C;

    // Condition code layout
    localparam int unsigned CCR_N = 11;
    localparam int unsigned CCR_Z = 10;
    localparam int unsigned CCR_V = 9;
    localparam int unsigned PK_MSB = 3;
    localparam int unsigned PULL_KIND_LSB = 16;
    localparam logic [1:0] PULL_FULL = 2'h1;
    localparam logic [1:0] PULL_PK = 2'h2;

    // Timing and reset values
    localparam logic [3:0] CYC_XFER = 4'h2;
    localparam logic [3:0] CYC_WORD_ZERO_TEST = 4'h6;
    localparam logic [3:0] CYC_WAI = 4'h8;
    localparam logic [19:0] SP_ADJ = 20'h00002;
    localparam logic [15:0] RST_CCR = 16'h0000;
    localparam logic [1:0] SEL_ABS = 2'h3;

    typedef enum logic [3:0] {
        CLS_NONE = 4'h0, CLS_WORD_ZERO_TEST = 4'h1, CLS_SP2IX = 4'h2, CLS_IX2SP = 4'h3,
        CLS_COPY = 4'h4, CLS_BANK = 4'h5, CLS_WAI = 4'h6, CLS_XAB = 4'h7,
        CLS_XDE = 4'h8, CLS_XDIX = 4'h9, CLS_XEIX = 4'hA
    } itxo_cls_t;

    typedef struct packed {
        itxo_cls_t cls;
        logic [1:0] a;
        logic [1:0] b;
    } itxo_dec_t;

    // Opcode to class plus source (a) and destination (b) selectors
    function automatic itxo_dec_t itxo_decode(input logic [15:0] op);
        itxo_dec_t r;
        r = '{CLS_NONE, 2'h0, 2'h0};
        case (op)
            OPC_WORD_ZERO_TEST_X: r = '{CLS_WORD_ZERO_TEST, 2'h0, 2'h0};
            OPC_WORD_ZERO_TEST_Y: r = '{CLS_WORD_ZERO_TEST, 2'h1, 2'h0};
            OPC_WORD_ZERO_TEST_Z: r = '{CLS_WORD_ZERO_TEST, 2'h2, 2'h0};
            OPC_WORD_ZERO_TEST_EXT: r = '{CLS_WORD_ZERO_TEST, SEL_ABS, 2'h0};
            OPC_TSX: r = '{CLS_SP2IX, 2'h0, 2'h0};
            OPC_TSY: r = '{CLS_SP2IX, 2'h1, 2'h0};
            OPC_TSZ: r = '{CLS_SP2IX, 2'h2, 2'h0};
            OPC_TXS: r = '{CLS_IX2SP, 2'h0, 2'h0};
            OPC_TYS: r = '{CLS_IX2SP, 2'h1, 2'h0};
            OPC_TZS: r = '{CLS_IX2SP, 2'h2, 2'h0};
            OPC_C12: r = '{CLS_COPY, 2'h0, 2'h1};
            OPC_C13: r = '{CLS_COPY, 2'h0, 2'h2};
            OPC_C21: r = '{CLS_COPY, 2'h1, 2'h0};
            OPC_C23: r = '{CLS_COPY, 2'h1, 2'h2};
            OPC_C31: r = '{CLS_COPY, 2'h2, 2'h0};
            OPC_C32: r = '{CLS_COPY, 2'h2, 2'h1};
            OPC_BK1: r = '{CLS_BANK, 2'h0, 2'h0};
            OPC_BK2: r = '{CLS_BANK, 2'h1, 2'h0};
            OPC_BK3: r = '{CLS_BANK, 2'h2, 2'h0};
            OPC_WAIT: r = '{CLS_WAI, 2'h0, 2'h0};
            OPC_XAB: r = '{CLS_XAB, 2'h0, 2'h0};
            OPC_XDE: r = '{CLS_XDE, 2'h0, 2'h0};
            OPC_XD1: r = '{CLS_XDIX, 2'h0, 2'h0};
            OPC_XD2: r = '{CLS_XDIX, 2'h1, 2'h0};
            OPC_XD3: r = '{CLS_XDIX, 2'h2, 2'h0};
            OPC_XE1: r = '{CLS_XEIX, 2'h0, 2'h0};
            OPC_XE2: r = '{CLS_XEIX, 2'h1, 2'h0};
            OPC_XE3: r = '{CLS_XEIX, 2'h2, 2'h0};
            default: r = '{CLS_NONE, 2'h0, 2'h0};
        endcase
        return r;
    endfunction

    function automatic logic [3:0] itxo_cycles(input itxo_cls_t cls);
        case (cls)
            CLS_WORD_ZERO_TEST: return CYC_WORD_ZERO_TEST;
            CLS_WAI: return CYC_WAI;
            default: return CYC_XFER;
        endcase
    endfunction

    // Result flags touch only the upper twelve bits; the bank field is kept
    function automatic logic [15:0] itxo_ccr_nzv(input logic [15:0] cond_code_reg, input logic n,
                                                 input logic z, input logic v);
        logic [15:0] r;
        r = cond_code_reg;
        r[CCR_N] = n;
        r[CCR_Z] = z;
        r[CCR_V] = v;
        return {r[15:PK_MSB+1], cond_code_reg[PK_MSB:0]};
    endfunction

    // Restore from a pulled stack copy: whole register or bank field only
    function automatic logic [15:0] itxo_ccr_pull(input logic [15:0] cond_code_reg,
                                                  input logic [15:0] val,
                                                  input logic [1:0] kind);
        case (kind)
            PULL_FULL: return val;
            PULL_PK: return {cond_code_reg[15:PK_MSB+1], val[PK_MSB:0]};
            default: return cond_code_reg;
        endcase
    endfunction
endpackage

// File: hdl/itxo_sync.sv
// Two-stage synchroniser for a single level.
// Assumes the input may change at any time relative to the core clock.
module itxo_sync
    import itxo_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;
    logic sync_q;

    // The first stage feeds only the second one
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// File: hdl/itxo_timer.sv
// Down counter that times one instruction.
// Assumes load is only raised while the counter is idle.
module itxo_timer
    import itxo_pkg::*;
#(
    parameter int unsigned W = 4
) (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic load_in,
    input wire logic [W-1:0] load_val_in,
    output logic done_out
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    // Count down to zero and stop there
    always_comb begin
        cnt_d = cnt_q;
        if (load_in) begin
            cnt_d = load_val_in;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - W'(1);
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Last cycle of the instruction
    assign done_out = (cnt_q == W'(1));
endmodule

// File: hdl/itxo_core.sv
// Decode and execute unit for the index transfer, exchange and wait instructions,
// with an APB slave that holds the register file and takes commands.
// Assumes an APB3 master on core_clk_in and a memory port that acks on this clock.
// Operation
// - Word test reads memory word indexed or absolute, sets N Z, clears V, six cycles.
// - Stack-to-index loads bank and index with stack bank:pointer plus two, two cycles.
// - Index-to-stack loads stack bank:pointer with index bank:register minus two.
// - Index copies move full twenty-bit value, two cycles, flags unchanged.
// - Bank-to-low-accumulator writes zero upper nibble and bank in lower nibble.
// - Wait instruction suspends until an interrupt, eight cycles, no flag change.
// - Byte accumulators swap, or word accumulators swap, in two cycles.
// - Double accumulator swaps with any index register in two cycles.
// - Second word accumulator swaps with any index register in two cycles.
// - Result flag updates touch only upper twelve condition bits, never the bank.
// - Full restore replaces all sixteen condition bits with the pulled copy.
// - Bank-only restore updates the bank field and keeps the other bits.
// - Branch timing keeps taken and not-taken counts, taken figure first.
//
// Added by the designer: the address map and the APB register port.
module itxo_core
    import itxo_pkg::*;
#(
    parameter logic [7:0] BR_TAKEN_CYC = 8'h06,
    parameter logic [7:0] BR_NOT_TAKEN_CYC = 8'h02
) (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic mem_rd_out,
    output logic [19:0] mem_addr_out,
    input wire logic mem_ack_in,
    input wire logic [15:0] mem_rdata_in,
    input wire logic irq_in,
    output logic busy_out,
    output logic wait_out
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_MEMW = 2'b10,
        ST_IRQW = 2'b11
    } itxo_state_t;

    itxo_state_t state_q, state_d;
    itxo_dec_t dec_q, dec_d, dec_new;
    logic [15:0] opc_q, opc_d, oper_q, oper_d;
    logic [15:0] d_q, d_d, e_q, e_d, ccr_q, ccr_d, mdata_q, mdata_d, mdata_eff;
    logic [19:0] idx_q [3];
    logic [19:0] idx_d [3];
    logic [19:0] sp_q, sp_d, maddr_q, maddr_d;
    logic [3:0] ek_q, ek_d;
    logic got_q, got_d, mrd_q, mrd_d, illegal_q, illegal_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d, busy_q, wait_q;
    logic irq_s, tmr_done, tmr_load, start, fin, wr_go, hit, ro;

    // Interrupt request is a pin and crosses into the core clock here
    itxo_sync u_irq_sync (
        .core_clk_in(core_clk_in),
        .arst_n_in(arst_n_in),
        .async_in(irq_in),
        .sync_out(irq_s)
    );

    itxo_timer #(.W(4)) u_timer (
        .core_clk_in(core_clk_in),
        .arst_n_in(arst_n_in),
        .load_in(tmr_load),
        .load_val_in(itxo_cycles(dec_new.cls)),
        .done_out(tmr_done)
    );

    // APB decode; pready is one wait state late so decode errors can be registered
    always_comb begin
        hit = 1'b1;
        ro = 1'b0;
        prdata_d = 32'h0000_0000;
        case (paddr_in)
            OFF_CMD: prdata_d = {oper_q, opc_q};
            OFF_STATUS: begin
                prdata_d = {26'h0, illegal_q, got_q, wait_q, busy_q, state_q};
                ro = 1'b1;
            end
            OFF_D: prdata_d = {16'h0000, d_q};
            OFF_E: prdata_d = {16'h0000, e_q};
            OFF_IX1: prdata_d = {12'h000, idx_q[0]};
            OFF_IX2: prdata_d = {12'h000, idx_q[1]};
            OFF_IX3: prdata_d = {12'h000, idx_q[2]};
            OFF_SP: prdata_d = {12'h000, sp_q};
            OFF_CCR: prdata_d = {16'h0000, ccr_q};
            OFF_PULL: prdata_d = 32'h0000_0000;
            OFF_EK: prdata_d = {28'h0000000, ek_q};
            OFF_TIMING: begin
                prdata_d = {16'h0000, BR_TAKEN_CYC, BR_NOT_TAKEN_CYC};
                ro = 1'b1;
            end
            default: hit = 1'b0;
        endcase
        pready_d = psel_in & penable_in & ~pready_q;
        // Writes while busy are refused so software cannot race the executing op
        pslverr_d = pready_d & (~hit | (pwrite_in & (ro | busy_q)));
        if (!pready_d || pwrite_in) begin
            prdata_d = 32'h0000_0000;
        end
        wr_go = psel_in & penable_in & pready_q & pwrite_in & ~pslverr_q;
    end

    // Instruction start, read data select and completion
    always_comb begin
        dec_new = itxo_decode(pwdata_in[15:0]);
        start = wr_go & (paddr_in == OFF_CMD) & (dec_new.cls != CLS_NONE);
        tmr_load = start;
        mdata_eff = got_q ? mdata_q : mem_rdata_in;
        fin = 1'b0;
        case (state_q)
            ST_RUN: fin = tmr_done & (dec_q.cls != CLS_WAI) &
                          ((dec_q.cls != CLS_WORD_ZERO_TEST) | got_q);
            ST_MEMW: fin = mem_ack_in;
            ST_IRQW: fin = irq_s;
            default: fin = 1'b0;
        endcase
    end

    // Next state of the sequencer and of the register file
    always_comb begin
        state_d = state_q;
        dec_d = dec_q;
        opc_d = opc_q;
        oper_d = oper_q;
        d_d = d_q;
        e_d = e_q;
        idx_d = idx_q;
        sp_d = sp_q;
        ccr_d = ccr_q;
        ek_d = ek_q;
        mdata_d = mdata_q;
        got_d = got_q;
        mrd_d = mrd_q;
        maddr_d = maddr_q;
        illegal_d = illegal_q;
        // Software writes land only while idle
        if (wr_go) begin
            case (paddr_in)
                OFF_CMD: begin
                    opc_d = pwdata_in[15:0];
                    oper_d = pwdata_in[31:16];
                    illegal_d = (dec_new.cls == CLS_NONE);
                end
                OFF_D: d_d = pwdata_in[15:0];
                OFF_E: e_d = pwdata_in[15:0];
                OFF_IX1: idx_d[0] = pwdata_in[19:0];
                OFF_IX2: idx_d[1] = pwdata_in[19:0];
                OFF_IX3: idx_d[2] = pwdata_in[19:0];
                OFF_SP: sp_d = pwdata_in[19:0];
                OFF_CCR: ccr_d = pwdata_in[15:0];
                OFF_PULL: ccr_d = itxo_ccr_pull(ccr_q, pwdata_in[15:0],
                    pwdata_in[PULL_KIND_LSB+1:PULL_KIND_LSB]);
                OFF_EK: ek_d = pwdata_in[3:0];
                default: ek_d = ek_q;
            endcase
        end
        if (start) begin
            state_d = ST_RUN;
            dec_d = dec_new;
            got_d = 1'b0;
            if (dec_new.cls == CLS_WORD_ZERO_TEST) begin
                // Indexed form adds the sign-extended offset to the twenty-bit index
                mrd_d = 1'b1;
                if (dec_new.a == SEL_ABS) begin
                    maddr_d = {ek_q, pwdata_in[31:16]};
                end else begin
                    maddr_d = idx_q[dec_new.a] + {{4{pwdata_in[31]}}, pwdata_in[31:16]};
                end
            end
        end
        if (mrd_q && mem_ack_in) begin
            mrd_d = 1'b0;
            got_d = 1'b1;
            mdata_d = mem_rdata_in;
        end
        if (state_q == ST_RUN && tmr_done && !fin) begin
            state_d = (dec_q.cls == CLS_WAI) ? ST_IRQW : ST_MEMW;
        end
        if (fin) begin
            state_d = ST_IDLE;
            case (dec_q.cls)
                CLS_WORD_ZERO_TEST: ccr_d = itxo_ccr_nzv(ccr_q, mdata_eff[15],
                                               (mdata_eff == 16'h0000), 1'b0);
                CLS_SP2IX: idx_d[dec_q.a] = sp_q + SP_ADJ;
                CLS_IX2SP: sp_d = idx_q[dec_q.a] - SP_ADJ;
                CLS_COPY: idx_d[dec_q.b] = idx_q[dec_q.a];
                CLS_BANK: d_d[7:0] = {4'h0, idx_q[dec_q.a][19:16]};
                CLS_XAB: d_d = {d_q[7:0], d_q[15:8]};
                CLS_XDE: begin
                    d_d = e_q;
                    e_d = d_q;
                end
                CLS_XDIX: begin
                    d_d = idx_q[dec_q.a][15:0];
                    idx_d[dec_q.a][15:0] = d_q;
                end
                CLS_XEIX: begin
                    e_d = idx_q[dec_q.a][15:0];
                    idx_d[dec_q.a][15:0] = e_q;
                end
                default: ccr_d = ccr_q;
            endcase
        end
    end

    // All state registers
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= ST_IDLE;
            dec_q <= '{CLS_NONE, 2'h0, 2'h0};
            opc_q <= 16'h0000;
            oper_q <= 16'h0000;
            d_q <= 16'h0000;
            e_q <= 16'h0000;
            idx_q <= '{20'h00000, 20'h00000, 20'h00000};
            sp_q <= 20'h00000;
            ccr_q <= RST_CCR;
            ek_q <= 4'h0;
            mdata_q <= 16'h0000;
            got_q <= 1'b0;
            mrd_q <= 1'b0;
            maddr_q <= 20'h00000;
            illegal_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            busy_q <= 1'b0;
            wait_q <= 1'b0;
        end else begin
            state_q <= state_d;
            dec_q <= dec_d;
            opc_q <= opc_d;
            oper_q <= oper_d;
            d_q <= d_d;
            e_q <= e_d;
            idx_q <= idx_d;
            sp_q <= sp_d;
            ccr_q <= ccr_d;
            ek_q <= ek_d;
            mdata_q <= mdata_d;
            got_q <= got_d;
            mrd_q <= mrd_d;
            maddr_q <= maddr_d;
            illegal_q <= illegal_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            busy_q <= (state_d != ST_IDLE);
            wait_q <= (state_d == ST_IRQW);
        end
    end

    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign mem_rd_out = mrd_q;
    assign mem_addr_out = maddr_q;
    assign busy_out = busy_q;
    assign wait_out = wait_q;

    // Checks on the executed results
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);

    sequence s_start_xfer;
        start && dec_new.cls != CLS_WORD_ZERO_TEST && dec_new.cls != CLS_WAI;
    endsequence
    sequence s_start_wai;
        start && dec_new.cls == CLS_WAI;
    endsequence

    property p_word_zero_test_flags;
        (fin && dec_q.cls == CLS_WORD_ZERO_TEST) |=> (ccr_q[CCR_V] == 1'b0) &&
            (ccr_q[CCR_Z] == ($past(mdata_eff) == 16'h0000)) &&
            (ccr_q[CCR_N] == $past(mdata_eff[15]));
    endproperty
    a_word_zero_test_flags: assert property (p_word_zero_test_flags) else $error("word test flags wrong");

    property p_xfer_two;
        s_start_xfer |=> busy_out [*2] ##1 !busy_out;
    endproperty
    a_xfer_two: assert property (p_xfer_two) else $error("transfer not two cycles");

    property p_sp_to_ix;
        (fin && dec_q.cls == CLS_SP2IX && dec_q.a == 2'h1) |=>
            idx_q[1] == $past(sp_q) + SP_ADJ;
    endproperty
    a_sp_to_ix: assert property (p_sp_to_ix) else $error("stack to index wrong");

    property p_ix_to_sp;
        (fin && dec_q.cls == CLS_IX2SP && dec_q.a == 2'h0) |=>
            sp_q == $past(idx_q[0]) - SP_ADJ;
    endproperty
    a_ix_to_sp: assert property (p_ix_to_sp) else $error("index to stack wrong");

    property p_copy_32;
        (fin && dec_q.cls == CLS_COPY && dec_q.a == 2'h2 && dec_q.b == 2'h1) |=>
            idx_q[1] == $past(idx_q[2]) && $stable(idx_q[2]) && $stable(ccr_q);
    endproperty
    a_copy_32: assert property (p_copy_32) else $error("index copy wrong");

    property p_bank_b;
        (fin && dec_q.cls == CLS_BANK) |=> d_q[7:4] == 4'h0 &&
            d_q[3:0] == $past(idx_q[dec_q.a][19:16]) && $stable(d_q[15:8]);
    endproperty
    a_bank_b: assert property (p_bank_b) else $error("bank to low acc wrong");

    property p_wai_hold;
        s_start_wai |=> busy_out [*8];
    endproperty
    a_wai_hold: assert property (p_wai_hold) else $error("wait ended too soon");

    property p_swap_ab;
        (fin && dec_q.cls == CLS_XAB) |=> d_q == {$past(d_q[7:0]), $past(d_q[15:8])};
    endproperty
    a_swap_ab: assert property (p_swap_ab) else $error("byte swap wrong");

    property p_swap_dx;
        (fin && dec_q.cls == CLS_XDIX && dec_q.a == 2'h0) |=>
            d_q == $past(idx_q[0][15:0]) && idx_q[0][15:0] == $past(d_q);
    endproperty
    a_swap_dx: assert property (p_swap_dx) else $error("double index swap wrong");

    property p_swap_ez;
        (fin && dec_q.cls == CLS_XEIX && dec_q.a == 2'h2) |=>
            e_q == $past(idx_q[2][15:0]) && idx_q[2][15:0] == $past(e_q);
    endproperty
    a_swap_ez: assert property (p_swap_ez) else $error("second acc swap wrong");

    property p_pk_keep;
        fin |=> $stable(ccr_q[PK_MSB:0]);
    endproperty
    a_pk_keep: assert property (p_pk_keep) else $error("bank field changed");

    property p_pull_pk;
        (wr_go && paddr_in == OFF_PULL && pwdata_in[17:16] == PULL_PK) |=>
            $stable(ccr_q[15:PK_MSB+1]) && ccr_q[PK_MSB:0] == $past(pwdata_in[PK_MSB:0]);
    endproperty
    a_pull_pk: assert property (p_pull_pk) else $error("bank restore wrong");
endmodule

// File: verification/itxo_core_bench.sv
// Self-checking bench for the index transfer, exchange and wait unit.
// Drives APB, a memory that acks one cycle late and the interrupt line itself.
module itxo_core_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import itxo_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, ack = 0, irq = 0;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0, prd;
    logic rdy, serr, mrd, busy, wt;
    logic [19:0] maddr, aseen;
    logic [15:0] mword = 16'h0, mdat = 16'h0;
    int err_total = 0, total_checks = 0;

    itxo_core i_dut (.core_clk_in(clk), .arst_n_in(rst_n), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy),
        .pslverr_out(serr), .mem_rd_out(mrd), .mem_addr_out(maddr), .mem_ack_in(ack),
        .mem_rdata_in(mdat), .irq_in(irq), .busy_out(busy), .wait_out(wt));

    // 20 MHz core clock
    initial begin
        forever #25 clk = ~clk;
    end

    // Memory answers a cycle late; data is inverted when not acked so stale data shows
    always @(posedge clk) begin
        ack <= mrd && !ack;
        mdat <= (mrd && !ack) ? mword : ~mword;
        irq <= wt;
        if (mrd) begin
            aseen <= maddr;
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One APB transfer; the request is held until pready is sampled high
    task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
        int n;
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        r = prd;
        e = serr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (rdy !== 1'b1) begin
            err_total++;
            end_of_test();
        end
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        xf(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] r;
        logic e;
        xf(1'b0, a, 32'h0, r, e);
        chk(nm, r, exp);
    endtask

    // Issue a command and count the cycles busy stays high, bounded for hangs
    task automatic run(input logic [31:0] cmd, output int n);
        wr(OFF_CMD, cmd);
        n = 0;
        while (busy === 1'b1 && n < 300) begin
            n++;
            @(posedge clk);
        end
        if (busy !== 1'b0) begin
            err_total++;
            end_of_test();
        end
    endtask

    // Stack and index transfers, with a wrap at the top of the 20-bit space
    task automatic t_xfer();
        int n;
        wr(OFF_CCR, 32'hA5A5);
        wr(OFF_SP, 32'hFFFFF);
        run(OPC_TSY, n);
        chk("tsy cycles", n, 2);
        rd(OFF_IX2, 32'h00001, "ix2");
        wr(OFF_SP, 32'h31000);
        run(OPC_TSX, n);
        rd(OFF_IX1, 32'h31002, "ix1");
        run(OPC_C12, n);
        rd(OFF_IX2, 32'h31002, "ix2 copy");
        wr(OFF_IX3, 32'h5ABCD);
        run(OPC_C32, n);
        rd(OFF_IX2, 32'h5ABCD, "ix2 from ix3");
        run(OPC_TZS, n);
        chk("tzs cycles", n, 2);
        rd(OFF_SP, 32'h5ABCB, "sp");
        rd(OFF_CCR, 32'hA5A5, "ccr kept");
    endtask

    // Exchanges, then a bank field into the low accumulator
    task automatic t_swap();
        int n;
        wr(OFF_D, 32'h1234);
        wr(OFF_E, 32'h5678);
        run(OPC_XAB, n);
        rd(OFF_D, 32'h3412, "d");
        run(OPC_XDE, n);
        rd(OFF_E, 32'h3412, "e");
        wr(OFF_IX1, 32'h70001);
        run(OPC_XD1, n);
        rd(OFF_D, 32'h0001, "d");
        rd(OFF_IX1, 32'h75678, "ix1");
        run(OPC_XE3, n);
        chk("xe cycles", n, 2);
        rd(OFF_E, 32'hABCD, "e");
        rd(OFF_IX3, 32'h53412, "ix3");
        wr(OFF_D, 32'hFFFF);
        run(OPC_BK3, n);
        rd(OFF_D, 32'hFF05, "d bank");
    endtask

    // Word test absolute then indexed with a negative offset
    task automatic t_test();
        int n;
        wr(OFF_CCR, 32'h0205);
        wr(OFF_EK, 32'h3);
        mword = 16'h8000;
        run({16'h1234, OPC_WORD_ZERO_TEST_EXT}, n);
        chk("word_zero_test cycles", n, 6);
        chk("abs addr", aseen, 20'h31234);
        rd(OFF_CCR, 32'h0805, "ccr neg");
        mword = 16'h0000;
        run({16'hFFFE, OPC_WORD_ZERO_TEST_X}, n);
        chk("idx addr", aseen, 20'h75676);
        rd(OFF_CCR, 32'h0405, "ccr zero");
    endtask

    // Wait runs at least its cycle count, then the interrupt releases it
    task automatic t_wait();
        int n;
        run(OPC_WAIT, n);
        chk("wait cycles", n >= 8, 1);
        rd(OFF_CCR, 32'h0405, "ccr");
    endtask

    // Condition code restore, bank only then whole, and an unmapped-address refusal
    task automatic t_misc();
        logic [31:0] r;
        logic e;
        wr(OFF_PULL, 32'h2FFF3);
        rd(OFF_CCR, 32'h0403, "ccr bank");
        wr(OFF_PULL, 32'h11234);
        rd(OFF_CCR, 32'h1234, "ccr full");
        rd(OFF_TIMING, 32'h0602, "timing");
        xf(1'b0, 8'h3C, 32'h0, r, e);
        chk("unmapped", {r[30:0], e}, 32'h1);
    endtask

    // Reset for five cycles, then the scenarios
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_xfer();
        t_swap();
        t_test();
        t_wait();
        t_misc();
        end_of_test();
    end
endmodule
